// [shared/csiwe_regs.svh]
`ifndef CSIWE_REGS_SVH
`define CSIWE_REGS_SVH
// register offsets inside the legacy socket register space
`define CSIWE_OFS_IRQ_CFG 8'h05
`define CSIWE_OFS_WIN_EN 8'h06
// reset values
`define CSIWE_RST_IRQ_CFG 8'h00
`define CSIWE_RST_WIN_EN 8'h00
// configuration register fields
`define CSIWE_SEL_MSB 7
`define CSIWE_SEL_LSB 4
`define CSIWE_SEL_NONE 4'h0
`define CSIWE_SEL_SMI 4'h2
`define CSIWE_BIT_CD 3
`define CSIWE_BIT_READY 2
`define CSIWE_BIT_BWARN 1
`define CSIWE_BIT_BDEAD 0
// window enable register fields
`define CSIWE_BIT_IO1 7
`define CSIWE_BIT_IO0 6
`define CSIWE_BIT_RSVD 5
`define CSIWE_MEM_MSB 4
`define CSIWE_WIN_WMASK 8'hdf
// synchronised pin indices
`define CSIWE_PIN_CDA 0
`define CSIWE_PIN_CDB 1
`define CSIWE_PIN_READY 2
`define CSIWE_PIN_BWARN 3
`define CSIWE_PIN_BDEAD 4
`define CSIWE_PIN_CARD_STATUS_CHANGE_SIGNAL 5
`define CSIWE_PIN_COUNT 6
`endif

// [shared/csiwe_pkg.sv]
package csiwe_pkg;
  typedef logic [7:0] csiwe_byte_t;
  typedef logic [3:0] csiwe_sel_t;
  typedef logic [3:0] csiwe_flags_t;
  typedef logic [15:0] csiwe_legacy_t;
endpackage : csiwe_pkg

// [shared/csiwe_route_if.sv]
`timescale 1ns/1ps
// carries the interrupt request and routing settings to the router
interface csiwe_route_if;
  import csiwe_pkg::*;
  logic req;
  csiwe_sel_t sel;
  logic diag;
  logic to_pci;
  csiwe_legacy_t legacy;
  logic smi;
  logic pci;
  modport ctrl (output req, sel, diag, to_pci, input legacy, smi, pci);
  modport router (input req, sel, diag, to_pci, output legacy, smi, pci);
endinterface : csiwe_route_if

// [design/csiwe_router.sv]
`timescale 1ns/1ps
`include "csiwe_regs.svh"
module csiwe_router (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // routing request and result
  csiwe_route_if.router rt
);
  import csiwe_pkg::*;

  logic go_pci;
  csiwe_legacy_t next_legacy;
  logic next_smi;
  logic next_pci;

  // pick at most one destination for the request
  assign go_pci = rt.to_pci | ((rt.sel == `CSIWE_SEL_NONE) & rt.diag);
  always_comb begin
    next_legacy = '0;
    next_smi = 1'b0;
    next_pci = 1'b0;
    if (rt.req) begin
      if (go_pci) begin
        next_pci = 1'b1;
      end else if (rt.sel == `CSIWE_SEL_SMI) begin
        next_smi = 1'b1;
      end else if (rt.sel != `CSIWE_SEL_NONE) begin
        next_legacy[rt.sel] = 1'b1;
      end
    end
  end

  // registered destination lines
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rt.legacy <= '0;
      rt.smi <= 1'b0;
      rt.pci <= 1'b0;
    end else begin
      rt.legacy <= next_legacy;
      rt.smi <= next_smi;
      rt.pci <= next_pci;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_req_pci;
    rt.req && rt.to_pci;
  endsequence
  AST_PCI_ROUTE: assert property (s_req_pci |=> rt.pci && !rt.smi && rt.legacy == '0)
    else $error("route bit set but pci interrupt not alone");
  AST_DIAG_ROUTE: assert property (rt.req && rt.diag && rt.sel == `CSIWE_SEL_NONE |=> rt.pci)
    else $error("diagnostic routing did not reach pci interrupt");
  AST_SMI_ROUTE: assert property (rt.req && !rt.to_pci && rt.sel == `CSIWE_SEL_SMI |=> rt.smi)
    else $error("select code two did not drive smi");
  AST_NO_ROUTE: assert property (!rt.to_pci && !rt.diag && rt.sel == `CSIWE_SEL_NONE
    |=> !rt.pci && !rt.smi && rt.legacy == '0)
    else $error("select zero drove a destination");
  AST_ONE_DEST: assert property ($onehot0({rt.legacy, rt.smi, rt.pci}))
    else $error("more than one destination driven");
  AST_REQ_DROP: assert property (!rt.req |=> !rt.pci && !rt.smi && rt.legacy == '0)
    else $error("destination driven without request");
endmodule : csiwe_router

// [design/csiwe_top.sv]
`timescale 1ns/1ps
`include "csiwe_regs.svh"
// Contract
// - select field bits 7..4 routes status-change interrupts; 0000 drives none, resets there
// - nonzero codes drive that numbered legacy line; code 0010 drives smi instead
// - select 0000 with diagnostic bit set sends interrupts to pci, route bit ignored
// - diagnostic bit clear: software sets route bit for pci, device honours it
// - card detect changes interrupt only while enable bit 3 is set
// - ready rising edge interrupts only while enable bit 2 set; resets to 0
// - battery warning interrupts only while enable bit 1 set; resets to 0
// - bit 0 enables battery dead or card status change interrupts; resets to 0
// - window register bit 7 enables io window 1, bit 6 io window 0
// - window register bits 4..0 enable memory windows 4..0
// - cycles to a disabled window are never claimed
// - all windows disabled after reset
// - window register bit 5 ignores writes and reads 0
// - flag of a disabled source reads 0; enabled source sets flag when active
// - route bit set sends interrupts to pci; clear follows select field
// - with an io card the ready flag always reads 0
module csiwe_top #(
  parameter int IO_WINDOWS = 2,
  parameter int MEM_WINDOWS = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // socket register port
  input wire csiwe_pkg::csiwe_byte_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire csiwe_pkg::csiwe_byte_t reg_wdata_i,
  output csiwe_pkg::csiwe_byte_t reg_rdata_o,
  output logic reg_rvalid_o,
  // settings held elsewhere in the bridge
  input wire logic card_is_io_i,
  input wire logic status_change_to_pci_route_i,
  input wire logic diag_status_change_pci_route_i,
  // card pins, asynchronous
  input wire logic card_detect_a_n_i,
  input wire logic card_detect_b_n_i,
  input wire logic card_ready_i,
  input wire logic battery_warning_i,
  input wire logic battery_dead_i,
  input wire logic card_status_change_signal_n_i,
  // status-change flags
  input wire csiwe_pkg::csiwe_flags_t change_flag_clear_i,
  output csiwe_pkg::csiwe_flags_t change_flags_o,
  output logic status_change_interrupt_o,
  // interrupt destinations
  output csiwe_pkg::csiwe_legacy_t legacy_irq_o,
  output logic smi_o,
  output logic pci_int_o,
  // window decode
  input wire logic [IO_WINDOWS-1:0] io_window_hit_i,
  input wire logic [MEM_WINDOWS-1:0] mem_window_hit_i,
  output logic [IO_WINDOWS-1:0] io_window_claim_o,
  output logic [MEM_WINDOWS-1:0] mem_window_claim_o
);
  import csiwe_pkg::*;

  // refuse window counts the register layout cannot hold
  if (IO_WINDOWS != 2 || MEM_WINDOWS != 5) begin : g_bad_param
    $error("csiwe_top supports two io and five memory windows only");
  end

  // register state
  csiwe_byte_t irq_cfg;
  csiwe_byte_t win_en;
  csiwe_byte_t next_irq_cfg;
  csiwe_byte_t next_win_en;
  csiwe_byte_t next_rdata;
  logic next_rvalid;

  // register writes and reads
  always_comb begin
    next_irq_cfg = irq_cfg;
    next_win_en = win_en;
    next_rdata = '0;
    next_rvalid = reg_rd_i;
    if (reg_wr_i && reg_addr_i == `CSIWE_OFS_IRQ_CFG) begin
      next_irq_cfg = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == `CSIWE_OFS_WIN_EN) begin
      next_win_en = reg_wdata_i & `CSIWE_WIN_WMASK;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `CSIWE_OFS_IRQ_CFG: next_rdata = irq_cfg;
        `CSIWE_OFS_WIN_EN: next_rdata = win_en & `CSIWE_WIN_WMASK;
        default: next_rdata = '0;
      endcase
    end
  end

  // register flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_cfg <= `CSIWE_RST_IRQ_CFG;
      win_en <= `CSIWE_RST_WIN_EN;
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      irq_cfg <= next_irq_cfg;
      win_en <= next_win_en;
      reg_rdata_o <= next_rdata;
      reg_rvalid_o <= next_rvalid;
    end
  end

  // named views of the configuration fields
  csiwe_sel_t status_change_irq_select;
  logic card_detect_irq_enable;
  logic ready_rise_irq_enable;
  logic battery_warning_irq_enable;
  logic battery_dead_irq_enable;
  assign status_change_irq_select = irq_cfg[`CSIWE_SEL_MSB:`CSIWE_SEL_LSB];
  assign card_detect_irq_enable = irq_cfg[`CSIWE_BIT_CD];
  assign ready_rise_irq_enable = irq_cfg[`CSIWE_BIT_READY];
  assign battery_warning_irq_enable = irq_cfg[`CSIWE_BIT_BWARN];
  assign battery_dead_irq_enable = irq_cfg[`CSIWE_BIT_BDEAD];

  // named views of the window enables
  logic io_window_one_enable;
  logic io_window_zero_enable;
  logic [MEM_WINDOWS-1:0] mem_window_enable;
  assign io_window_one_enable = win_en[`CSIWE_BIT_IO1];
  assign io_window_zero_enable = win_en[`CSIWE_BIT_IO0];
  assign mem_window_enable = win_en[`CSIWE_MEM_MSB:0];

  // a cycle is claimed only for a window that is enabled
  assign io_window_claim_o = io_window_hit_i & {io_window_one_enable, io_window_zero_enable};
  assign mem_window_claim_o = mem_window_hit_i & mem_window_enable;

  // pin synchronisers and edge history
  logic [`CSIWE_PIN_COUNT-1:0] pin_raw;
  logic [`CSIWE_PIN_COUNT-1:0] pin_meta;
  logic [`CSIWE_PIN_COUNT-1:0] pin_sync;
  logic [`CSIWE_PIN_COUNT-1:0] pin_prev;
  assign pin_raw[`CSIWE_PIN_CDA] = card_detect_a_n_i;
  assign pin_raw[`CSIWE_PIN_CDB] = card_detect_b_n_i;
  assign pin_raw[`CSIWE_PIN_READY] = card_ready_i;
  assign pin_raw[`CSIWE_PIN_BWARN] = battery_warning_i;
  assign pin_raw[`CSIWE_PIN_BDEAD] = battery_dead_i;
  assign pin_raw[`CSIWE_PIN_CARD_STATUS_CHANGE_SIGNAL] = ~card_status_change_signal_n_i;

  // two flops per pin, then one history flop for edges
  for (genvar p = 0; p < `CSIWE_PIN_COUNT; p++) begin : g_sync
    logic next_meta;
    logic next_sync;
    logic next_prev;
    always_comb begin
      next_meta = pin_raw[p];
      next_sync = pin_meta[p];
      next_prev = pin_sync[p];
    end
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        pin_meta[p] <= 1'b0;
        pin_sync[p] <= 1'b0;
        pin_prev[p] <= 1'b0;
      end else begin
        pin_meta[p] <= next_meta;
        pin_sync[p] <= next_sync;
        pin_prev[p] <= next_prev;
      end
    end
  end

  // source events, each as a one-cycle pulse
  logic cd_change;
  logic ready_rise;
  logic bwarn_rise;
  logic bdead_cond;
  logic bdead_prev;
  logic bdead_rise;
  assign cd_change = (pin_sync[`CSIWE_PIN_CDA] ^ pin_prev[`CSIWE_PIN_CDA])
    | (pin_sync[`CSIWE_PIN_CDB] ^ pin_prev[`CSIWE_PIN_CDB]);
  assign ready_rise = pin_sync[`CSIWE_PIN_READY] & ~pin_prev[`CSIWE_PIN_READY];
  assign bwarn_rise = pin_sync[`CSIWE_PIN_BWARN] & ~pin_prev[`CSIWE_PIN_BWARN];
  // memory cards report battery dead, io cards report the status-change pin
  assign bdead_cond = card_is_io_i ? pin_sync[`CSIWE_PIN_CARD_STATUS_CHANGE_SIGNAL] : pin_sync[`CSIWE_PIN_BDEAD];
  assign bdead_prev = card_is_io_i ? pin_prev[`CSIWE_PIN_CARD_STATUS_CHANGE_SIGNAL] : pin_prev[`CSIWE_PIN_BDEAD];
  assign bdead_rise = bdead_cond & ~bdead_prev;

  // per-flag set and enable vectors
  csiwe_flags_t flag_set;
  csiwe_flags_t flag_en;
  assign flag_set[`CSIWE_BIT_CD] = cd_change;
  assign flag_set[`CSIWE_BIT_READY] = ready_rise;
  assign flag_set[`CSIWE_BIT_BWARN] = bwarn_rise;
  assign flag_set[`CSIWE_BIT_BDEAD] = bdead_rise;
  assign flag_en[`CSIWE_BIT_CD] = card_detect_irq_enable;
  assign flag_en[`CSIWE_BIT_READY] = ready_rise_irq_enable & ~card_is_io_i;
  assign flag_en[`CSIWE_BIT_BWARN] = battery_warning_irq_enable;
  assign flag_en[`CSIWE_BIT_BDEAD] = battery_dead_irq_enable;

  // sticky flags: a set in the clear cycle wins, a disabled source holds 0
  csiwe_flags_t next_flags;
  always_comb begin
    next_flags = ((change_flags_o & ~change_flag_clear_i) | flag_set) & flag_en;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      change_flags_o <= '0;
    end else begin
      change_flags_o <= next_flags;
    end
  end

  // request is the or of all enabled set flags
  assign status_change_interrupt_o = |change_flags_o;

  // routing to a single destination
  csiwe_route_if rt ();
  assign rt.req = status_change_interrupt_o;
  assign rt.sel = status_change_irq_select;
  assign rt.diag = diag_status_change_pci_route_i;
  assign rt.to_pci = status_change_to_pci_route_i;
  assign legacy_irq_o = rt.legacy;
  assign smi_o = rt.smi;
  assign pci_int_o = rt.pci;

  csiwe_router u_router (
    .clk_i (clk_i),
    .srst_i (srst_i),
    .rt (rt)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_win_write;
    reg_wr_i && reg_addr_i == `CSIWE_OFS_WIN_EN;
  endsequence
  sequence s_cfg_write;
    reg_wr_i && reg_addr_i == `CSIWE_OFS_IRQ_CFG;
  endsequence

  AST_RSVD_ZERO: assert property (s_win_write |=> win_en[`CSIWE_BIT_RSVD] == 1'b0)
    else $error("reserved window bit took a write");
  AST_RSVD_READ: assert property (reg_rd_i && reg_addr_i == `CSIWE_OFS_WIN_EN
    |=> reg_rvalid_o && reg_rdata_o[`CSIWE_BIT_RSVD] == 1'b0)
    else $error("reserved window bit read as one");
  AST_WIN_WRITE: assert property (s_win_write |=>
    win_en[`CSIWE_BIT_IO1] == $past(reg_wdata_i[`CSIWE_BIT_IO1])
    && win_en[`CSIWE_MEM_MSB:0] == $past(reg_wdata_i[`CSIWE_MEM_MSB:0]))
    else $error("window enable write not stored");
  AST_CFG_WRITE: assert property (s_cfg_write |=> irq_cfg == $past(reg_wdata_i))
    else $error("configuration write not stored");
  AST_IO_CLAIM: assert property (!io_window_one_enable |-> !io_window_claim_o[1])
    else $error("disabled io window 1 claimed a cycle");
  AST_MEM_CLAIM: assert property ((mem_window_claim_o & ~mem_window_enable) == '0)
    else $error("disabled memory window claimed a cycle");
  AST_CD_MASK: assert property (!card_detect_irq_enable |=> !change_flags_o[`CSIWE_BIT_CD])
    else $error("card detect flag set while disabled");
  AST_CD_SET: assert property (cd_change && card_detect_irq_enable |=> change_flags_o[`CSIWE_BIT_CD])
    else $error("card detect change lost");
  AST_READY_RISE: assert property (ready_rise && ready_rise_irq_enable && !card_is_io_i
    |=> change_flags_o[`CSIWE_BIT_READY] ##1 status_change_interrupt_o)
    else $error("ready rise did not set flag");
  AST_READY_IO: assert property (card_is_io_i |=> !change_flags_o[`CSIWE_BIT_READY])
    else $error("ready flag set with io card");
  AST_BWARN_MASK: assert property (!battery_warning_irq_enable |=> !change_flags_o[`CSIWE_BIT_BWARN])
    else $error("battery warning flag set while disabled");
  AST_BDEAD_SET: assert property (bdead_rise && battery_dead_irq_enable
    |=> change_flags_o[`CSIWE_BIT_BDEAD])
    else $error("battery dead or status change lost");
  AST_WIN_RESET: assert property (disable iff (1'b0) $past(srst_i) |-> win_en == `CSIWE_RST_WIN_EN)
    else $error("windows not disabled after reset");

  // flag set and clear steps, seen one cycle before the flag register moves
  sequence s_set_seen;
    (flag_set & flag_en) != '0;
  endsequence
  sequence s_clear_only;
    (change_flag_clear_i & flag_set) == '0;
  endsequence

  AST_IO0_CLAIM: assert property (!io_window_zero_enable |-> !io_window_claim_o[0])
    else $error("disabled io window 0 claimed a cycle");
  AST_IO_CLAIM_ON: assert property (io_window_claim_o == (io_window_hit_i & {io_window_one_enable, io_window_zero_enable}))
    else $error("enabled io window did not claim its hit");
  AST_MEM_CLAIM_ON: assert property (mem_window_claim_o == (mem_window_hit_i & mem_window_enable))
    else $error("enabled memory window did not claim its hit");
  AST_READY_MASK: assert property (!ready_rise_irq_enable |=> !change_flags_o[`CSIWE_BIT_READY])
    else $error("ready flag set while disabled");
  AST_BDEAD_MASK: assert property (!battery_dead_irq_enable |=> !change_flags_o[`CSIWE_BIT_BDEAD])
    else $error("battery dead flag set while disabled");
  AST_BWARN_SET: assert property (bwarn_rise && battery_warning_irq_enable
    |=> change_flags_o[`CSIWE_BIT_BWARN])
    else $error("battery warning rise lost");
  AST_FLAG_CLEAR: assert property (s_clear_only
    |=> (change_flags_o & $past(change_flag_clear_i)) == '0)
    else $error("flag survived a clear without a set");
  AST_SET_WINS: assert property (s_set_seen
    |=> (change_flags_o & $past(flag_set & flag_en)) == $past(flag_set & flag_en))
    else $error("enabled source event did not set its flag");
  AST_CFG_READ: assert property (reg_rd_i && reg_addr_i == `CSIWE_OFS_IRQ_CFG
    |=> reg_rvalid_o && reg_rdata_o == $past(irq_cfg))
    else $error("configuration read returned wrong value");
  AST_WIN_IO0: assert property (s_win_write |=> win_en[`CSIWE_BIT_IO0] == $past(reg_wdata_i[`CSIWE_BIT_IO0]))
    else $error("io window 0 enable write not stored");
  AST_CFG_HOLD: assert property (!(reg_wr_i && reg_addr_i == `CSIWE_OFS_IRQ_CFG)
    |=> $stable(irq_cfg))
    else $error("configuration changed without a write");
  AST_WIN_HOLD: assert property (!(reg_wr_i && reg_addr_i == `CSIWE_OFS_WIN_EN)
    |=> $stable(win_en))
    else $error("window enables changed without a write");
endmodule : csiwe_top

// [dv/csiwe_card_model.sv]
`timescale 1ns/1ps
// card side of the socket: pins follow the requested levels one clock later
module csiwe_card_model (
  // clock
  input wire logic clk_i,
  // requested levels: card_status_change_signal_n, bdead, bwarn, ready, cd_b_n, cd_a_n
  input wire logic [5:0] want_i,
  // card pins
  output logic card_detect_a_n_o,
  output logic card_detect_b_n_o,
  output logic card_ready_o,
  output logic battery_warning_o,
  output logic battery_dead_o,
  output logic card_status_change_signal_n_o
);
  // card present, all conditions quiet, status change released
  logic [5:0] pins = 6'h20;
  // pins move only just after an edge, like a card clocked off the same source
  always @(posedge clk_i) begin
    pins <= want_i;
  end
  // pin fan-out
  assign card_detect_a_n_o = pins[0];
  assign card_detect_b_n_o = pins[1];
  assign card_ready_o = pins[2];
  assign battery_warning_o = pins[3];
  assign battery_dead_o = pins[4];
  assign card_status_change_signal_n_o = pins[5];
endmodule : csiwe_card_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h expected %h", $time, (g), (e)); end end
module tb_top;
  import csiwe_pkg::*;
  logic clk_i, srst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, card_is_io_i, to_pci, diag;
  csiwe_byte_t reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic cda_n, cdb_n, rdy, bwarn, bdead, card_status_change_signal_n, status_change_interrupt_o, smi_o, pci_int_o;
  logic [5:0] want;
  csiwe_flags_t change_flag_clear_i, change_flags_o;
  csiwe_legacy_t legacy_irq_o;
  logic [1:0] io_hit, io_claim;
  logic [4:0] mem_hit, mem_claim;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // clock source
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // device under test and card
  csiwe_top u_csiwe_top (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .card_is_io_i(card_is_io_i), .status_change_to_pci_route_i(to_pci),
    .diag_status_change_pci_route_i(diag), .card_detect_a_n_i(cda_n), .card_detect_b_n_i(cdb_n),
    .card_ready_i(rdy), .battery_warning_i(bwarn), .battery_dead_i(bdead),
    .card_status_change_signal_n_i(card_status_change_signal_n), .change_flag_clear_i(change_flag_clear_i),
    .change_flags_o(change_flags_o), .status_change_interrupt_o(status_change_interrupt_o),
    .legacy_irq_o(legacy_irq_o), .smi_o(smi_o), .pci_int_o(pci_int_o), .io_window_hit_i(io_hit),
    .mem_window_hit_i(mem_hit), .io_window_claim_o(io_claim), .mem_window_claim_o(mem_claim));
  csiwe_card_model u_csiwe_card_model (.clk_i(clk_i), .want_i(want), .card_detect_a_n_o(cda_n),
    .card_detect_b_n_o(cdb_n), .card_ready_o(rdy), .battery_warning_o(bwarn), .battery_dead_o(bdead),
    .card_status_change_signal_n_o(card_status_change_signal_n));
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("CHECK FAILED %0t run did not finish", $time);
      close_out();
    end
  end
  // one register write, strobe held for one edge
  task automatic wr(input csiwe_byte_t a, input csiwe_byte_t d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // one register read, answer sampled just after the edge that follows the strobe
  task automatic rd(input csiwe_byte_t a, input csiwe_byte_t e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rvalid_o, 1'b1)
    `CHK(reg_rdata_o, e)
  endtask : rd
  // move card pins and let the synchroniser and flags settle
  task automatic pins(input logic [5:0] v);
    @(posedge clk_i);
    want <= v;
    repeat (6) @(posedge clk_i);
    #1;
  endtask : pins
  // one-cycle clear of all flags
  task automatic clr();
    @(posedge clk_i);
    change_flag_clear_i <= 4'hf;
    @(posedge clk_i);
    change_flag_clear_i <= 4'h0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : clr
  // reset state of registers, windows and outputs
  task automatic t_reset();
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    `CHK({io_claim, mem_claim}, 7'h00)
    `CHK({change_flags_o, smi_o, pci_int_o}, 6'h00)
    `CHK(legacy_irq_o, 16'h0000)
  endtask : t_reset
  // window enables, reserved bit and unmapped offsets
  task automatic t_windows();
    wr(8'h06, 8'hff);
    rd(8'h06, 8'hdf);
    `CHK(io_claim, 2'h3)
    `CHK(mem_claim, 5'h1f)
    wr(8'h06, 8'h41);
    #1;
    `CHK(io_claim, 2'h1)
    `CHK(mem_claim, 5'h01)
    wr(8'h06, 8'h00);
    #1;
    `CHK({io_claim, mem_claim}, 7'h00)
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h05, 8'ha5);
    rd(8'h05, 8'ha5);
  endtask : t_windows
  // each change source with its enable on; ready and card detect also with it off
  task automatic t_sources();
    wr(8'h05, 8'h00);
    pins(6'h24);
    `CHK(change_flags_o, 4'h0)
    pins(6'h20);
    wr(8'h05, 8'h3f);
    pins(6'h24);
    `CHK(change_flags_o, 4'h4)
    `CHK(status_change_interrupt_o, 1'b1)
    `CHK(legacy_irq_o, 16'h0008)
    clr();
    `CHK({change_flags_o, legacy_irq_o}, 20'h0_0000)
    pins(6'h25);
    `CHK(change_flags_o, 4'h8)
    clr();
    pins(6'h2d);
    `CHK(change_flags_o, 4'h2)
    clr();
    pins(6'h3d);
    `CHK(change_flags_o, 4'h1)
    clr();
    wr(8'h05, 8'h37);
    pins(6'h3c);
    `CHK(change_flags_o, 4'h0)
    pins(6'h38);
    @(posedge clk_i);
    card_is_io_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    clr();
    pins(6'h1c);
    `CHK(change_flags_o, 4'h1)
  endtask : t_sources
  // every select code against both routing bits, one flag pending
  task automatic t_routing();
    logic ep, es;
    csiwe_legacy_t el;
    for (int s = 0; s < 16; s++) begin
      for (int m = 0; m < 4; m++) begin
        @(posedge clk_i);
        to_pci <= m[0];
        diag <= m[1];
        wr({s[3:0], 4'h7}, 8'h00);
        wr(8'h05, {s[3:0], 4'h5});
        repeat (3) @(posedge clk_i);
        #1;
        ep = m[0] || (s == 0 && m[1]);
        es = !ep && s == 2;
        el = (ep || s == 0 || s == 2) ? 16'h0000 : 16'h0001 << s;
        `CHK(pci_int_o, ep)
        `CHK(smi_o, es)
        `CHK(legacy_irq_o, el)
      end
    end
    wr(8'h05, 8'h04);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK({change_flags_o, pci_int_o}, 5'h00)
  endtask : t_routing
  // a set and a clear of one flag in the same cycle, then a plain clear
  task automatic t_clear();
    @(posedge clk_i);
    card_is_io_i <= 1'b0;
    wr(8'h05, 8'h02);
    pins(6'h14);
    @(posedge clk_i);
    want <= 6'h1c;
    repeat (3) @(posedge clk_i);
    change_flag_clear_i <= 4'h2;
    @(posedge clk_i);
    change_flag_clear_i <= 4'h0;
    #1;
    `CHK(change_flags_o, 4'h2)
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(pci_int_o, 1'b1)
    clr();
    `CHK({change_flags_o, status_change_interrupt_o}, 5'h00)
  endtask : t_clear
  // main sequence
  initial begin
    srst_i = 1'b1;
    {reg_wr_i, reg_rd_i, card_is_io_i, to_pci, diag} = 5'h00;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    change_flag_clear_i = 4'h0;
    want = 6'h20;
    io_hit = 2'h3;
    mem_hit = 5'h1f;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_windows();
    t_sources();
    t_routing();
    t_clear();
    close_out();
  end
endmodule : tb_top
